// >>> rtl/cpu_clock_pkg.sv
// Shared constants, types and helper functions for the processor clock and baud tick block.
// Assumes a single 125 MHz system clock; the PLL output is modelled as a rate, not a real clock.
package cpu_clock_pkg;

	// Clock rates in MHz
	localparam int CLK_MHZ      = 125;              // System clock feeding this block
	localparam int REF_MHZ      = 24;               // Crystal reference
	localparam int PLL_MHZ      = 480;              // Multiplied reference
	localparam int PLL_MULT     = PLL_MHZ / REF_MHZ; // Reference multiplier

	// Serial rates in baud
	localparam int BAUD_HZ      = 230_000;          // Normal serial rate
	localparam int BAUD_HALF_HZ = 115_000;          // Rate with doubling bit set

	// Datapath widths
	localparam int ACC_W        = 12;               // Phase accumulator, holds 2500 + 480
	localparam int DIV_W        = 9;                // Baud divisor, holds 417

	// Register byte offsets
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;  // processor_control_status
	localparam logic [7:0] SERIAL_OFFSET = 8'h04;  // Serial rate doubling bits
	localparam logic [7:0] STATUS_OFFSET = 8'h08;  // Applied rate, read only

	// Field positions
	localparam int CTRL_TRISTATE_BIT  = 0;         // 1 releases the output pin
	localparam int CTRL_INVERT_BIT    = 1;         // 1 inverts the output pin
	localparam int CTRL_SPEED_LSB     = 2;         // Two-bit rate request
	localparam int SERIAL_DBL0_BIT    = 0;         // port_zero_rate_double
	localparam int SERIAL_DBL1_BIT    = 1;         // port_one_rate_double
	localparam int STATUS_SPEED_LSB   = 0;         // Two-bit applied rate
	localparam int STATUS_PENDING_BIT = 2;         // Request not yet applied

	// Rate codes
	typedef logic [1:0] speed_t;
	localparam speed_t SPEED_12 = 2'h0;
	localparam speed_t SPEED_24 = 2'h1;
	localparam speed_t SPEED_48 = 2'h2;

	// Reset values
	localparam speed_t SPEED_RESET    = SPEED_12;
	localparam logic   TRISTATE_RESET = 1'b0;
	localparam logic   INVERT_RESET   = 1'b0;
	localparam logic   DBL_RESET      = 1'b0;

	// Processor clock in MHz; the spare code falls back to the slowest rate
	function automatic int cpu_mhz(input speed_t s);
		case (s)
			SPEED_48: cpu_mhz = 48;
			SPEED_24: cpu_mhz = 24;
			default:  cpu_mhz = 12;
		endcase
	endfunction

	// Accumulator limit for one half period, in PLL cycles times CLK_MHZ
	function automatic logic [ACC_W-1:0] acc_limit(input speed_t s);
		acc_limit = ACC_W'((PLL_MHZ / (2 * cpu_mhz(s))) * CLK_MHZ);
	endfunction

	// Processor clocks per serial bit, rounded to nearest
	function automatic logic [DIV_W-1:0] baud_div(input speed_t s, input logic dbl);
		int hz;
		int baud;
		hz       = cpu_mhz(s) * 1_000_000;
		baud     = dbl ? BAUD_HALF_HZ : BAUD_HZ;
		baud_div = DIV_W'((hz + baud / 2) / baud);
	endfunction

endpackage

// >>> rtl/baud_link_if.sv
// Carrier between the clock core and one baud tick generator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface baud_link_if;
	import cpu_clock_pkg::*;
	logic   cpu_rise;   // One-cycle pulse per processor clock rise
	speed_t speed;      // Applied processor clock rate
	logic   dbl;        // Rate doubling bit of this port
	logic   tick;       // One-cycle pulse per serial bit
	modport core (output cpu_rise, output speed, output dbl, input tick);
	modport gen  (input cpu_rise, input speed, input dbl, output tick);
endinterface

// >>> rtl/baud_tick_gen.sv
// Baud tick generator for one serial port, counting processor clock rises.
// Assumes the core sends a clean rise pulse and the applied rate on the link.
`timescale 1ns/10ps
module baud_tick_gen
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Link to the clock core
	baud_link_if.gen  lnk
);
	import cpu_clock_pkg::*;

	// All state of the generator
	typedef struct packed
	{
		logic [DIV_W-1:0] cnt;   // Rises seen in this bit
		logic             tick;  // Registered overflow pulse
	} gen_state_t;

	gen_state_t       q;        // Current state
	gen_state_t       d;        // Next state
	logic [DIV_W-1:0] div_now;  // Divisor for the applied rate
	logic [DIV_W-1:0] cnt_inc;  // Count after this rise

	// Divisor tracks rate and doubling with no firmware help
	assign div_now = baud_div(lnk.speed, lnk.dbl);
	assign cnt_inc = DIV_W'(q.cnt + 1'b1);

	// Next state; a compare by >= also recovers when a rate drop shrinks the divisor
	always_comb
	begin
		d      = q;
		d.tick = 1'b0;
		if (lnk.cpu_rise)
		begin
			if (cnt_inc >= div_now)
			begin
				d.cnt  = '0;
				d.tick = 1'b1;
			end
			else
			begin
				d.cnt = cnt_inc;
			end
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign lnk.tick = q.tick;

	// Overflow on the last rise of a bit
	property p_tick_on_wrap;
		@(posedge clk) disable iff (!rst_n)
		(lnk.cpu_rise && (cnt_inc >= div_now)) |=> (q.tick && q.cnt == '0);
	endproperty
	a_tick_on_wrap: assert property (p_tick_on_wrap) else $error("baud tick missing at wrap");

	// Tick only follows a processor clock rise
	property p_tick_cause;
		@(posedge clk) disable iff (!rst_n)
		q.tick |-> $past(lnk.cpu_rise);
	endproperty
	a_tick_cause: assert property (p_tick_cause) else $error("baud tick without clock rise");

	// Between rises the count holds
	property p_cnt_hold;
		@(posedge clk) disable iff (!rst_n)
		!lnk.cpu_rise |=> $stable(q.cnt) && !q.tick;
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("baud count moved without rise");

endmodule

// >>> rtl/cpu_clock_gen.sv
// Processor clock generator with mirrored output pin, Wishbone registers and two baud tick sources.
// Assumes a 125 MHz system clock; the 480 MHz PLL is emulated by a fractional phase accumulator,
// so each edge lands on the first system clock edge at or after its ideal time and the duty is 50% on average.
`timescale 1ns/10ps
module cpu_clock_gen
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Processor clock towards the core
	output logic             cpu_clk,
	output logic             cpu_clk_rise,
	output cpu_clock_pkg::speed_t cpu_speed,
	// Output pin, enable active low
	output logic             clock_output_pin,
	output logic             clock_output_pin_oe_n,
	// Serial bit ticks
	output logic             serial_port_zero_tick,
	output logic             serial_port_one_tick
);
	import cpu_clock_pkg::*;

	// All state of the core
	typedef struct packed
	{
		logic             tristate;   // Output pin released
		logic             invert;     // Output pin inverted
		speed_t           speed_req;  // Rate firmware asked for
		logic             dbl0;       // port_zero_rate_double
		logic             dbl1;       // port_one_rate_double
		speed_t           speed_cur;  // Rate actually running
		logic [ACC_W-1:0] acc;        // PLL cycles owed to this half period
		logic             phase;      // Processor clock level
		logic             rise;       // Rising edge pulse
		logic             pin;        // Output pin level
		logic             ack;        // Bus acknowledge
		logic [31:0]      rdat;       // Registered read data
	} core_state_t;

	core_state_t      q;          // Current state
	core_state_t      d;          // Next state
	logic             access;     // Bus cycle answered this edge
	logic             wr_ctrl;    // Write hitting the control register
	logic             wr_serial;  // Write hitting the serial register
	logic [ACC_W-1:0] limit;      // Half period length for the applied rate
	logic [ACC_W-1:0] sum;        // Accumulator after this system cycle

	// Bus strobes; only byte lane 0 holds live bits
	assign access    = wb_cyc_i & wb_stb_i & ~q.ack;
	assign wr_ctrl   = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == CTRL_OFFSET);
	assign wr_serial = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == SERIAL_OFFSET);

	// Every system cycle credits the PLL rate to the accumulator
	assign limit = acc_limit(q.speed_cur);
	assign sum   = ACC_W'(q.acc + ACC_W'(PLL_MHZ));

	// Next state
	always_comb
	begin
		d      = q;
		d.ack  = access;
		d.rise = 1'b0;

		// Register writes land on the edge that raises ack
		if (wr_ctrl)
		begin
			d.tristate  = wb_dat_i[CTRL_TRISTATE_BIT];
			d.invert    = wb_dat_i[CTRL_INVERT_BIT];
			d.speed_req = wb_dat_i[CTRL_SPEED_LSB +: 2];
		end
		else if (wr_serial)
		begin
			d.dbl0 = wb_dat_i[SERIAL_DBL0_BIT];
			d.dbl1 = wb_dat_i[SERIAL_DBL1_BIT];
		end

		// Read mux; unmapped addresses answer with zero
		if (access && !wb_we_i)
		begin
			d.rdat = '0;
			if (wb_adr_i == CTRL_OFFSET)
			begin
				d.rdat[CTRL_TRISTATE_BIT]   = q.tristate;
				d.rdat[CTRL_INVERT_BIT]     = q.invert;
				d.rdat[CTRL_SPEED_LSB +: 2] = q.speed_req;
			end
			else if (wb_adr_i == SERIAL_OFFSET)
			begin
				d.rdat[SERIAL_DBL0_BIT] = q.dbl0;
				d.rdat[SERIAL_DBL1_BIT] = q.dbl1;
			end
			else if (wb_adr_i == STATUS_OFFSET)
			begin
				d.rdat[STATUS_SPEED_LSB +: 2]  = q.speed_cur;
				d.rdat[STATUS_PENDING_BIT]     = (q.speed_cur != q.speed_req);
			end
		end

		// Divide the PLL rate down; at most one toggle per system cycle even at 48 MHz
		if (sum >= limit)
		begin
			d.acc   = ACC_W'(sum - limit);
			d.phase = ~q.phase;
			d.rise  = ~q.phase;
			// New rate taken only as the high phase closes at a falling edge, so no runt pulse appears
			if (q.phase)
				d.speed_cur = q.speed_req;
		end
		else
		begin
			d.acc = sum;
		end

		// Pin follows the clock; inversion applies the same edge
		d.pin = d.phase ^ d.invert;
	end

	// State register with reset to the slowest rate
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			q           <= '0;
			q.tristate  <= TRISTATE_RESET;
			q.invert    <= INVERT_RESET;
			q.speed_req <= SPEED_RESET;
			q.speed_cur <= SPEED_RESET;
			q.dbl0      <= DBL_RESET;
			q.dbl1      <= DBL_RESET;
		end
		else
		begin
			q <= d;
		end
	end

	// Outputs, all from flops
	assign wb_dat_o              = q.rdat;
	assign wb_ack_o              = q.ack;
	assign cpu_clk               = q.phase;
	assign cpu_clk_rise          = q.rise;
	assign cpu_speed             = q.speed_cur;
	assign clock_output_pin      = q.pin;
	assign clock_output_pin_oe_n = q.tristate;

	// Links to the two baud generators
	baud_link_if lnk0 ();
	baud_link_if lnk1 ();

	// Both ports see the same applied rate, each its own doubling bit
	assign lnk0.cpu_rise = q.rise;
	assign lnk0.speed    = q.speed_cur;
	assign lnk0.dbl      = q.dbl0;
	assign lnk1.cpu_rise = q.rise;
	assign lnk1.speed    = q.speed_cur;
	assign lnk1.dbl      = q.dbl1;

	// Tick source for serial_port_zero
	baud_tick_gen u_baud0
	(
		.clk   (clk),
		.rst_n (rst_n),
		.lnk   (lnk0.gen)
	);

	// Tick source for serial_port_one
	baud_tick_gen u_baud1
	(
		.clk   (clk),
		.rst_n (rst_n),
		.lnk   (lnk1.gen)
	);

	assign serial_port_zero_tick = lnk0.tick;
	assign serial_port_one_tick  = lnk1.tick;

	// Reset leaves both rates at 12 MHz
	property p_reset_speed;
		@(posedge clk)
		!rst_n |=> (q.speed_cur == SPEED_12) && (q.speed_req == SPEED_12);
	endproperty
	a_reset_speed: assert property (p_reset_speed) else $error("rate not 12 MHz after reset");

	// A control write is held as the new request
	property p_ctrl_write;
		@(posedge clk) disable iff (!rst_n)
		wr_ctrl |=> (q.speed_req == $past(wb_dat_i[CTRL_SPEED_LSB +: 2])) && q.ack;
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("rate request not stored");

	// Accumulator never owes a full half period
	property p_acc_bound;
		@(posedge clk) disable iff (!rst_n)
		q.acc < limit;
	endproperty
	a_acc_bound: assert property (p_acc_bound) else $error("divider accumulator overran");

	// Pin is the clock with optional inversion, enable from the control bit
	property p_pin_follow;
		@(posedge clk) disable iff (!rst_n)
		(q.pin == (q.phase ^ q.invert)) && (clock_output_pin_oe_n == q.tristate);
	endproperty
	a_pin_follow: assert property (p_pin_follow) else $error("output pin does not follow clock");

	// Rate changes only right after a falling edge
	property p_switch_boundary;
		@(posedge clk) disable iff (!rst_n)
		$changed(q.speed_cur) |-> ($past(q.phase) && !q.phase);
	endproperty
	a_switch_boundary: assert property (p_switch_boundary) else $error("rate switched mid period");

	// Rise marks the start of a high phase and is a single pulse
	property p_rise_pulse;
		@(posedge clk) disable iff (!rst_n)
		q.rise |-> (q.phase && !$past(q.phase)) ##1 !q.rise;
	endproperty
	a_rise_pulse: assert property (p_rise_pulse) else $error("runt processor clock pulse");

	// Acknowledge is a single pulse; a strobe held past ack is answered again every second cycle
	property p_ack_pulse;
		@(posedge clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("bus acknowledge held too long");

	// Pin control bits land with the control write
	property p_ctrl_pin_bits;
		@(posedge clk) disable iff (!rst_n)
		wr_ctrl |=> (q.tristate == $past(wb_dat_i[CTRL_TRISTATE_BIT])) && (q.invert == $past(wb_dat_i[CTRL_INVERT_BIT]));
	endproperty
	a_ctrl_pin_bits: assert property (p_ctrl_pin_bits) else $error("pin control bits not stored");

	// Doubling bits land with the serial write, one per port
	property p_serial_write;
		@(posedge clk) disable iff (!rst_n)
		wr_serial |=> (q.dbl0 == $past(wb_dat_i[SERIAL_DBL0_BIT])) && (q.dbl1 == $past(wb_dat_i[SERIAL_DBL1_BIT]));
	endproperty
	a_serial_write: assert property (p_serial_write) else $error("doubling bits not stored");

	// Only a control write moves the rate request
	property p_req_stable;
		@(posedge clk) disable iff (!rst_n)
		!wr_ctrl |=> $stable(q.speed_req);
	endproperty
	a_req_stable: assert property (p_req_stable) else $error("rate request moved without write");

	// The applied rate only ever becomes the requested one
	property p_rate_hold;
		@(posedge clk) disable iff (!rst_n)
		$changed(q.speed_cur) |-> (q.speed_cur == $past(q.speed_req));
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("applied rate not the request");

	// The clock level moves only when the accumulator overflows
	property p_phase_step;
		@(posedge clk) disable iff (!rst_n)
		$changed(q.phase) |-> $past(sum >= limit);
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("clock toggled without overflow");

	// Status read returns the applied rate and the pending flag
	property p_read_status;
		@(posedge clk) disable iff (!rst_n)
		(access && !wb_we_i && (wb_adr_i == STATUS_OFFSET)) |=> wb_ack_o && (wb_dat_o[STATUS_SPEED_LSB +: 2] == $past(q.speed_cur)) && (wb_dat_o[STATUS_PENDING_BIT] == $past(q.speed_cur != q.speed_req));
	endproperty
	a_read_status: assert property (p_read_status) else $error("status read data wrong");

	// High phase at 48 MHz lasts one or two system cycles
	property p_high_48;
		@(posedge clk) disable iff (!rst_n)
		(q.rise && (cpu_mhz(q.speed_cur) == 48)) |-> q.phase ##[1:2] !q.phase;
	endproperty
	a_high_48: assert property (p_high_48) else $error("48 MHz high phase length wrong");

	// High phase at 24 MHz lasts two or three system cycles
	property p_high_24;
		@(posedge clk) disable iff (!rst_n)
		(q.rise && (cpu_mhz(q.speed_cur) == 24)) |-> q.phase[*2] ##[1:2] !q.phase;
	endproperty
	a_high_24: assert property (p_high_24) else $error("24 MHz high phase length wrong");

	// High phase at 12 MHz lasts five or six system cycles
	property p_high_12;
		@(posedge clk) disable iff (!rst_n)
		(q.rise && (cpu_mhz(q.speed_cur) == 12)) |-> q.phase[*5] ##[1:2] !q.phase;
	endproperty
	a_high_12: assert property (p_high_12) else $error("12 MHz high phase length wrong");

	// Low phase at 48 MHz, new rate included, lasts one or two cycles
	property p_low_48;
		@(posedge clk) disable iff (!rst_n)
		($fell(q.phase) && (cpu_mhz(q.speed_cur) == 48)) |-> (!q.phase) ##[1:2] q.phase;
	endproperty
	a_low_48: assert property (p_low_48) else $error("48 MHz low phase length wrong");

	// Low phase at 12 MHz lasts five or six cycles
	property p_low_12;
		@(posedge clk) disable iff (!rst_n)
		($fell(q.phase) && (cpu_mhz(q.speed_cur) == 12)) |-> (!q.phase)[*5] ##[1:2] q.phase;
	endproperty
	a_low_12: assert property (p_low_12) else $error("12 MHz low phase length wrong");

endmodule

// >>> sim/serial_core_model.sv
// Far-side model of the core's serial logic: counts processor clock rises per serial bit.
// Assumes rise and tick pulses are one system cycle wide.
`timescale 1ns/10ps
module serial_core_model
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pulses from the clock block
	input  wire logic cpu_rise,
	input  wire logic tick0,
	input  wire logic tick1,
	// Rises per bit and tick counts
	output int        gap0,
	output int        gap1,
	output int        cnt0,
	output int        cnt1
);
	int run0; // Rises since last port zero tick
	int run1; // Rises since last port one tick
	// Gap after a rate change is mixed, so the bench waits for several ticks
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			run0 <= 0;
			run1 <= 0;
			cnt0 <= 0;
			cnt1 <= 0;
			gap0 <= 0;
			gap1 <= 0;
		end
		else
		begin
			// Non-blocking, so the bench reads settled counts at each edge
			run0 <= tick0 ? 0 : run0 + int'(cpu_rise);
			run1 <= tick1 ? 0 : run1 + int'(cpu_rise);
			// Tick closes one bit time
			if (tick0)
			begin
				gap0 <= run0 + int'(cpu_rise);
				cnt0 <= cnt0 + 1;
			end
			if (tick1)
			begin
				gap1 <= run1 + int'(cpu_rise);
				cnt1 <= cnt1 + 1;
			end
		end
	end
endmodule

// >>> sim/test_cpu_clock_gen.sv
// Self-checking bench for the processor clock block over classic Wishbone.
// Assumes the serial core model measures the tick spacing.
`timescale 1ns/10ps
module test_cpu_clock_gen;
	import cpu_clock_pkg::*;
	logic        clk = 1'b0;   // 125 MHz system clock
	logic        rst_n = 1'b0; // Synchronous reset
	logic        cyc = 1'b0;   // Bus request lines
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic        ack;
	logic        cpu_clk;
	logic        rise;
	speed_t      speed;
	logic        pin;
	logic        oe_n;
	logic        tick0;
	logic        tick1;
	int          gap0, gap1, cnt0, cnt1;
	int          miscompares = 0;
	int          num_checks = 0;
	logic [31:0] q;
	speed_t      prev_speed = SPEED_12;
	logic        prev_clk = 1'b0;
	speed_t      rates[3] = '{SPEED_48, SPEED_24, SPEED_12};
	int          mhzs[3] = '{48, 24, 12};
	int          r, hi, pm, d0, d1;

	always #4 clk = ~clk;

	cpu_clock_gen uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.cpu_clk(cpu_clk), .cpu_clk_rise(rise), .cpu_speed(speed), .clock_output_pin(pin),
		.clock_output_pin_oe_n(oe_n), .serial_port_zero_tick(tick0), .serial_port_one_tick(tick1));
	serial_core_model far (.clk(clk), .rst_n(rst_n), .cpu_rise(rise), .tick0(tick0), .tick1(tick1),
		.gap0(gap0), .gap1(gap1), .cnt0(cnt0), .cnt1(cnt1));

	// Verdict and end of run
	task automatic end_sim();
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Compare one value
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("mismatch %s expected %h seen %h", name, exp, seen);
			miscompares++;
		end
	endtask

	// One classic cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		{cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, s};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
		begin
			miscompares++;
			end_sim();
		end
		else
		begin
			q = dat_r;
			{cyc, stb} <= 2'b00;
		end
	endtask

	// Bounded wait for a rate to be applied
	task automatic wait_speed(input speed_t s);
		int n;
		n = 0;
		while (speed !== s && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		if (speed !== s)
		begin
			miscompares++;
			end_sim();
		end
	endtask

	// Rises, high cycles and pin mismatches over a window
	task automatic sample(input int cycles, input logic inv);
		r = 0;
		hi = 0;
		pm = 0;
		repeat (cycles)
		begin
			@(posedge clk);
			r += int'(rise === 1'b1);
			hi += int'(cpu_clk === 1'b1);
			pm += int'(pin !== (cpu_clk ^ inv) || oe_n !== 1'b0);
		end
	endtask

	// Nearest rounded divisor for a rate
	function automatic int div_exp(input int mhz, input int baud);
		return (mhz * 1000000 + baud / 2) / baud;
	endfunction

	// Rate may move only in the cycle the processor clock falls
	always @(posedge clk)
	begin
		if (rst_n && speed !== prev_speed)
			check("speed_at_fall", {cpu_clk, prev_clk}, 32'h1);
		prev_speed = speed;
		prev_clk = cpu_clk;
	end

	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, STATUS_OFFSET, 32'h0, 4'hF);
		check("status_reset", q, 32'h0);
		check("speed_reset", speed, SPEED_12);
		wb(1'b0, SERIAL_OFFSET, 32'h0, 4'hF);
		check("serial_reset", q, 32'h0);
		sample(1250, 1'b0);
		check("rises_12_reset", r >= 119 && r <= 121, 1);
		foreach (rates[i])
		begin
			wb(1'b1, CTRL_OFFSET, 32'({rates[i], 1'b0, 1'b0}) | 32'(i % 2 * 2), 4'h1);
			wait_speed(rates[i]);
			wb(1'b0, STATUS_OFFSET, 32'h0, 4'hF);
			check("status_applied", q, 32'(rates[i]));
			sample(1250, 1'(i % 2));
			check("rises", r >= mhzs[i] * 10 - 1 && r <= mhzs[i] * 10 + 1, 1);
			check("duty", hi >= 620 && hi <= 630, 1);
			check("pin_follows", pm, 0);
			for (int d = 0; d < 2; d++)
			begin
				wb(1'b1, SERIAL_OFFSET, d ? 32'h1 : 32'h2, 4'h1);
				d1 = cnt0 + 3;
				pm = cnt1 + 3;
				for (int n = 0; n < 20000 && (cnt0 < d1 || cnt1 < pm); n++)
					@(posedge clk);
				if (cnt0 < d1 || cnt1 < pm)
				begin
					miscompares++;
					end_sim();
				end
				check("gap_zero", gap0, div_exp(mhzs[i], d ? 115000 : 230000));
				check("gap_one", gap1, div_exp(mhzs[i], d ? 230000 : 115000));
				// Rate error measured on the port that runs at the normal rate
				d0 = d ? gap1 : gap0;
				check("rate_error", d0 > 0 ? 100 * (mhzs[i] * 1000000 / d0 - 230000) / 230000 : 1, 0);
			end
		end
		// Spare rate code runs at 12 MHz and reads back as written
		wb(1'b1, CTRL_OFFSET, 32'hC, 4'h1);
		wait_speed(2'h3);
		wb(1'b0, STATUS_OFFSET, 32'h0, 4'hF);
		check("status_spare", q, 32'h3);
		sample(1250, 1'b0);
		check("rises_spare", r >= 119 && r <= 121, 1);
		check("pin_spare", pm, 0);
		// Reset in mid-run falls back to 12 MHz and clears the bits
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		check("speed_rereset", speed, SPEED_12);
		wb(1'b0, CTRL_OFFSET, 32'h0, 4'hF);
		check("ctrl_rereset", q, 32'h0);
		wb(1'b0, SERIAL_OFFSET, 32'h0, 4'hF);
		check("serial_rereset", q, 32'h0);
		wb(1'b1, CTRL_OFFSET, 32'h1, 4'h1);
		@(posedge clk);
		check("pin_released", oe_n, 1'b1);
		wb(1'b1, CTRL_OFFSET, 32'h3, 4'h0);
		wb(1'b1, STATUS_OFFSET, 32'hFF, 4'hF);
		wb(1'b0, CTRL_OFFSET, 32'h0, 4'hF);
		check("ctrl_sel_ignored", q, 32'h1);
		wb(1'b0, STATUS_OFFSET, 32'h0, 4'hF);
		check("status_read_only", q, 32'(SPEED_12));
		wb(1'b0, 8'h0C, 32'h0, 4'hF);
		check("unmapped", q, 32'h0);
		wb(1'b1, CTRL_OFFSET, 32'h0, 4'h1);
		@(posedge clk);
		check("pin_driven", oe_n, 1'b0);
		end_sim();
	end
endmodule
